/* File: shared/motion_wake_pkg.sv */
// Constants, types and register map of the motion wake detector
// How it works
// - Threshold is 8-bit field of first parameter register, one milli-g per LSB.
// - Zero threshold disables motion wake; both pins revert to ordinary functions.
// - Bit 6 of second parameter picks pin: 1 second, 0 first.
// - Six-bit count of accelerometer samples ignored after motion wake starts.
// - Wake event sets flag at bit 2 of first status register.
// - Host read of first status register clears the wake flag.
// - Clearing the wake flag returns selected pin to programmed initial level.
// - Every wake event inverts the selected interrupt line.
// - Stays in motion wake, raising further events, until commanded otherwise.
// - Writing non-zero threshold clears flag; in motion wake it also sets pins per programmed settings.
package motion_wake_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned AXIS_W = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_THRESH  = 8'h00;
   localparam logic [7:0] OFS_PINBLNK = 8'h04;
   localparam logic [7:0] OFS_CMD     = 8'h08;
   localparam logic [7:0] OFS_FIRST_STATUS_REGISTER = 8'h0c;
   localparam logic [7:0] OFS_IRQSTAT = 8'h10;
   localparam logic [7:0] OFS_IRQMASK = 8'h14;
   localparam logic [7:0] OFS_MODE    = 8'h18;

   // Field positions
   localparam int unsigned PIN_SEL_BIT  = 6;
   localparam int unsigned INIT_LVL_BIT = 7;
   localparam int unsigned BLNK_MSB     = 5;
   localparam int unsigned WAKE_BIT     = 2;
   localparam int unsigned IRQ_WAKE_BIT = 0;
   localparam int unsigned MODE_ON_BIT  = 0;
   localparam int unsigned MODE_BLK_LSB = 8;

   // Reset values
   localparam logic [7:0] THRESH_RST  = 8'h00;
   localparam logic [7:0] PINBLNK_RST = 8'h00;
   localparam logic       MASK_RST    = 1'b0;

   // Command codes
   localparam logic [7:0] CMD_WAKE_ENTER = 8'h01;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {
      MW_OFF = 1'b0,
      MW_ON  = 1'b1
   } mw_state_t;

   typedef struct packed {
      logic signed [AXIS_W-1:0] x;
      logic signed [AXIS_W-1:0] y;
      logic signed [AXIS_W-1:0] z;
   } accel_sample_t;

   typedef struct packed {
      logic first_interrupt_pin;
      logic second_interrupt_pin;
   } int_pins_t;
endpackage : motion_wake_pkg

/* File: rtl/motion_wake.sv */
// Motion wake detector with AXI4-Lite register slave
`timescale 1ns/1ns
module motion_wake (
   // Clock and reset
   input  wire logic                           aclk,
   input  wire logic                           aresetn,
   // AXI4-Lite write address
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [motion_wake_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                     s_axi_awprot,
   // AXI4-Lite write data
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   input  wire logic [motion_wake_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   // AXI4-Lite write response
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   output logic [1:0]                          s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   input  wire logic [motion_wake_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                     s_axi_arprot,
   // AXI4-Lite read data
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   output logic [motion_wake_pkg::DATA_W-1:0]  s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   // Accelerometer samples
   input  wire logic                           accel_valid,
   input  wire motion_wake_pkg::accel_sample_t accel_sample,
   // Interrupt pins and their ordinary functions
   input  wire motion_wake_pkg::int_pins_t     int_normal,
   output motion_wake_pkg::int_pins_t          int_pins,
   // Interrupt to system
   output logic                                irq
);
   import motion_wake_pkg::*;

   // Register state
   logic [7:0]       thresh_r;
   logic [7:0]       pinblnk_r;
   logic             wake_flag_r;
   logic             irq_stat_r;
   logic             irq_mask_r;
   mw_state_t        state_r;
   logic [BLNK_MSB:0] blank_cnt_r;
   logic             pin_lvl_r;
   logic             pin_sel_r;
   int_pins_t        pins_r;
   logic             init_lvl_r;

   // Bus state
   logic             bvalid_r;
   logic [1:0]       bresp_r;
   logic             rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0]       rresp_r;

   // Decoded strobes
   logic             wr_en;
   logic             rd_en;
   logic             wr_lane0;
   logic             wr_thresh;
   logic             wr_pinblnk;
   logic             wr_cmd;
   logic             wr_irqstat;
   logic             wr_irqmask;

   // Read and mode decode
   logic             rd_first_status_register;
   logic             start_mw;
   logic             stop_mw;
   logic             sample_hit;
   logic             wake_evt;
   logic             flag_clr;

   // Command and sample terms
   logic             cmd_enter;
   logic             cmd_leave;
   logic             thr_set_zero;
   logic             thr_set_live;
   logic             blank_done;
   logic [2:0]       axis_hit;
   logic [DATA_W-1:0] rd_word;

   // Magnitude of a signed axis, unsigned at the same width so the most negative value fits
   function automatic logic [AXIS_W-1:0] axis_mag(input logic signed [AXIS_W-1:0] v);
      logic [AXIS_W-1:0] m;
      m = v[AXIS_W-1] ? AXIS_W'(-v) : AXIS_W'(v);
      return m;
   endfunction : axis_mag

   // Strict compare; a sample equal to the threshold is quiet
   function automatic logic over_thr(input logic signed [AXIS_W-1:0] v,
                                     input logic [7:0] thr);
      return axis_mag(v) > {{(AXIS_W-8){1'b0}}, thr};
   endfunction : over_thr

   // Unmapped offsets answer with an error response
   function automatic logic is_reg(input logic [ADDR_W-1:0] a);
      return a == OFS_THRESH || a == OFS_PINBLNK || a == OFS_CMD || a == OFS_FIRST_STATUS_REGISTER
          || a == OFS_IRQSTAT || a == OFS_IRQMASK || a == OFS_MODE;
   endfunction : is_reg

   // Write address and data are taken together, so arrival order does not matter
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign s_axi_wready  = s_axi_awready;
   assign wr_en         = s_axi_awready;
   assign s_axi_arready = !rvalid_r;
   assign rd_en         = s_axi_arvalid && s_axi_arready;

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

   // Writable registers are one byte wide; only lane 0 carries them
   assign wr_lane0   = wr_en && s_axi_wstrb[0];
   always_comb begin
      wr_thresh  = 1'b0;
      wr_pinblnk = 1'b0;
      wr_cmd     = 1'b0;
      wr_irqstat = 1'b0;
      wr_irqmask = 1'b0;
      if (wr_lane0) begin
         unique case (s_axi_awaddr)
            OFS_THRESH: begin
               wr_thresh = 1'b1;
            end
            OFS_PINBLNK: begin
               wr_pinblnk = 1'b1;
            end
            OFS_CMD: begin
               wr_cmd = 1'b1;
            end
            OFS_IRQSTAT: begin
               wr_irqstat = 1'b1;
            end
            OFS_IRQMASK: begin
               wr_irqmask = 1'b1;
            end
            default: begin
               wr_thresh = 1'b0;
            end
         endcase
      end
   end
   assign rd_first_status_register = rd_en && s_axi_araddr == OFS_FIRST_STATUS_REGISTER;

   // Command and threshold writes, split by their effect on the mode
   assign cmd_enter    = wr_cmd && s_axi_wdata[7:0] == CMD_WAKE_ENTER;
   assign cmd_leave    = wr_cmd && s_axi_wdata[7:0] != CMD_WAKE_ENTER;
   assign thr_set_zero = wr_thresh && s_axi_wdata[7:0] == 8'h00;
   assign thr_set_live = wr_thresh && s_axi_wdata[7:0] != 8'h00;

   // Entry only by command, and only with a usable threshold
   assign start_mw = (cmd_enter && thresh_r != 8'h00)
                   || (thr_set_live && state_r == MW_ON);
   // Any other command or a zero threshold leaves the mode
   assign stop_mw  = cmd_leave
                   || thr_set_zero;

   // Each axis is judged alone against the threshold
   assign axis_hit[0] = over_thr(accel_sample.x, thresh_r);
   assign axis_hit[1] = over_thr(accel_sample.y, thresh_r);
   assign axis_hit[2] = over_thr(accel_sample.z, thresh_r);
   assign sample_hit  = |axis_hit;
   assign blank_done  = blank_cnt_r == '0;
   // Samples inside the blanking window are dropped
   assign wake_evt = state_r == MW_ON && !start_mw && !stop_mw && accel_valid
                  && blank_done && sample_hit;

   // A live threshold write clears the flag even while the mode is off
   assign flag_clr = rd_first_status_register || start_mw || thr_set_live;

   // Parameter registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thresh_r  <= THRESH_RST;
         pinblnk_r <= PINBLNK_RST;
      end else begin
         if (wr_thresh) begin
            thresh_r <= s_axi_wdata[7:0];
         end
         if (wr_pinblnk) begin
            pinblnk_r <= s_axi_wdata[7:0];
         end
      end
   end

   // Mode; the device never leaves on its own after an event
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= MW_OFF;
      end else if (stop_mw) begin
         state_r <= MW_OFF;
      end else if (start_mw) begin
         state_r <= MW_ON;
      end
   end

   // Blanking counter, reloaded at each start
   // Count is frozen while the mode is off
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blank_cnt_r <= '0;
      end else if (start_mw) begin
         blank_cnt_r <= pinblnk_r[BLNK_MSB:0];
      end else if (state_r == MW_ON && accel_valid && blank_cnt_r != '0) begin
         blank_cnt_r <= blank_cnt_r - 1'b1;
      end
   end

   // Wake flag: a new event beats a clearing read in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_flag_r <= 1'b0;
      end else if (wake_evt) begin
         wake_flag_r <= 1'b1;
      end else if (flag_clr) begin
         wake_flag_r <= 1'b0;
      end
   end

   // Pin selection and level, latched at start so a later edit cannot glitch pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_sel_r  <= 1'b0;
         pin_lvl_r  <= 1'b0;
         init_lvl_r <= 1'b0;
      end else if (start_mw) begin
         pin_sel_r  <= pinblnk_r[PIN_SEL_BIT];
         pin_lvl_r  <= pinblnk_r[INIT_LVL_BIT];
         init_lvl_r <= pinblnk_r[INIT_LVL_BIT];
      end else if (wake_evt) begin
         pin_lvl_r <= !pin_lvl_r;
      end else if (flag_clr && wake_flag_r) begin
         pin_lvl_r <= init_lvl_r;
      end
   end

   // Pins: motion wake level on the chosen pin, ordinary function elsewhere
   // Pins lag the level register by one edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_r <= '0;
      end else if (state_r == MW_ON) begin
         pins_r.first_interrupt_pin <= pin_sel_r ? int_normal.first_interrupt_pin : pin_lvl_r;
         pins_r.second_interrupt_pin <= pin_sel_r ? pin_lvl_r : int_normal.second_interrupt_pin;
      end else begin
         pins_r <= int_normal;
      end
   end
   assign int_pins = pins_r;

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= 1'b0;
      end else if (wake_evt) begin
         irq_stat_r <= 1'b1;
      end else if (wr_irqstat && s_axi_wdata[IRQ_WAKE_BIT]) begin
         irq_stat_r <= 1'b0;
      end
   end

   // Mask gates only the system interrupt, never the pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask_r <= MASK_RST;
      end else if (wr_irqmask) begin
         irq_mask_r <= s_axi_wdata[IRQ_WAKE_BIT];
      end
   end

   assign irq = irq_stat_r && irq_mask_r;

   // Write response one cycle after the taking edge
   // An early bready while idle is harmless
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end else if (wr_en) begin
         bvalid_r <= 1'b1;
         bresp_r  <= is_reg(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read data mux; status shows the flag as it stands before the clear
   always_comb begin
      rd_word = '0;
      unique case (s_axi_araddr)
         OFS_THRESH: begin
            rd_word[7:0] = thresh_r;
         end
         OFS_PINBLNK: begin
            rd_word[7:0] = pinblnk_r;
         end
         OFS_FIRST_STATUS_REGISTER: begin
            rd_word[WAKE_BIT] = wake_flag_r;
         end
         OFS_IRQSTAT: begin
            rd_word[IRQ_WAKE_BIT] = irq_stat_r;
         end
         OFS_IRQMASK: begin
            rd_word[IRQ_WAKE_BIT] = irq_mask_r;
         end
         OFS_MODE: begin
            rd_word[MODE_ON_BIT] = state_r == MW_ON;
            rd_word[MODE_BLK_LSB +: BLNK_MSB+1] = blank_cnt_r;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // Read data one cycle after the taking edge
   // An early rready while idle is harmless
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= RESP_OKAY;
      end else if (rd_en) begin
         rvalid_r <= 1'b1;
         rresp_r  <= is_reg(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_r  <= rd_word;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule : motion_wake

/* File: dv/motion_wake_checker.sv */
// Port assertions for the motion wake detector
`timescale 1ns/1ns
module motion_wake_checker (
   // Clock and reset
   input wire logic                       aclk,
   input wire logic                       aresetn,
   // Register bus handshakes
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic [1:0]                 s_axi_bresp,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready,
   input wire logic [31:0]                s_axi_rdata,
   // Samples and pins
   input wire logic                       accel_valid,
   input wire motion_wake_pkg::int_pins_t int_normal,
   input wire motion_wake_pkg::int_pins_t int_pins,
   input wire logic                       irq
);
   import motion_wake_pkg::*;
   wire wr_take = s_axi_awvalid && s_axi_awready;
   wire rd_take = s_axi_arvalid && s_axi_arready;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_aw_ready_rule: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
      else $error("awready not tied to valids");
   a_w_ready_pair: assert property (s_axi_wready == s_axi_awready) else $error("wready differs");
   a_ar_ready_rule: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
   a_write_answer: assert property (wr_take |=> s_axi_bvalid) else $error("no write response");
   a_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("no read response");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   // Two-stage pin pipeline, so two quiet edges must freeze the pins
   a_pin_quiet: assert property (
      (!accel_valid && !wr_take && !rd_take && $stable(int_normal))[*2] |=> $stable(int_pins))
      else $error("pins moved without cause");
   a_irq_rise_cause: assert property ($rose(irq) |-> $past(accel_valid) || $past(wr_take))
      else $error("irq rose without cause");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_take)) else $error("irq fell without write");
endmodule : motion_wake_checker

bind motion_wake motion_wake_checker i_motion_wake_checker (.*);

/* File: dv/host_irq_watch.sv */
// Host interrupt input that counts pin transitions
`timescale 1ns/1ns
module host_irq_watch (
   // Clock
   input  wire logic                       aclk,
   // Pins from the device
   input  wire motion_wake_pkg::int_pins_t int_pins,
   // Transitions seen
   output int unsigned                     edges
);
   import motion_wake_pkg::*;
   int_pins_t prev_r = 2'h0;
   initial edges = 0;
   // Edge host of either polarity sees every change
   always @(posedge aclk) begin
      if (int_pins !== prev_r) edges <= edges + 1;
      prev_r <= int_pins;
   end
endmodule : host_irq_watch

/* File: dv/tb_top.sv */
// Self-checking bench for the motion wake detector
`timescale 1ns/1ns
module tb_top;
   import motion_wake_pkg::*;
   logic          aclk = 1'b0, aresetn = 1'b0, accel_valid = 1'b0;
   logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [7:0]    s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [2:0]    s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]    s_axi_wstrb = 4'hf;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   accel_sample_t accel_sample = 48'h0;
   int_pins_t     int_normal = 2'h2, int_pins;
   int unsigned   edges, base, bad_count = 0, checked = 0;

   always #4 aclk = ~aclk;
   motion_wake i_motion_wake (.*);
   host_irq_watch i_host_irq_watch (.*);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, 32'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd

   task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      @(posedge aclk);
      accel_valid <= 1'b1;
      accel_sample <= {x, y, z};
      @(posedge aclk);
      accel_valid <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : smp

   task automatic pins(input logic [1:0] exp);
      repeat (2) @(posedge aclk);
      chk({30'h0, int_pins}, {30'h0, exp});
   endtask : pins

   task automatic wrap_up();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // Whole run is under two hundred cycles
   initial begin
      #300000;
      bad_count++;
      wrap_up();
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      pins(2'h2);
      rd(OFS_THRESH, 32'h0, RESP_OKAY);
      rd(OFS_PINBLNK, 32'h0, RESP_OKAY);
      rd(OFS_IRQMASK, 32'h0, RESP_OKAY);
      rd(8'h20, 32'h0, RESP_SLVERR);
      wr(OFS_PINBLNK, 32'h02);
      wr(OFS_THRESH, 32'h64);
      wr(OFS_CMD, 32'h01);
      pins(2'h0);
      rd(OFS_MODE, 32'h201, RESP_OKAY);
      repeat (2) smp(16'h01f4, 16'h0000, 16'h0000);
      pins(2'h0);
      rd(OFS_FIRST_STATUS_REGISTER, 32'h0, RESP_OKAY);
      smp(16'h0064, 16'hff9c, 16'h0064);
      pins(2'h0);
      base = edges;
      smp(16'h0000, 16'hff9b, 16'h0000);
      pins(2'h2);
      chk({31'h0, irq}, 32'h0);
      rd(OFS_IRQSTAT, 32'h1, RESP_OKAY);
      wr(OFS_IRQMASK, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_IRQSTAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      smp(16'h0000, 16'h0000, 16'h00c8);
      pins(2'h0);
      smp(16'h0000, 16'h0000, 16'hfed4);
      pins(2'h2);
      chk(edges - base, 32'h3);
      chk({31'h0, irq}, 32'h1);
      rd(OFS_FIRST_STATUS_REGISTER, 32'h4, RESP_OKAY);
      pins(2'h0);
      rd(OFS_FIRST_STATUS_REGISTER, 32'h0, RESP_OKAY);
      smp(16'h012c, 16'h0000, 16'h0000);
      wr(OFS_THRESH, 32'h50);
      rd(OFS_FIRST_STATUS_REGISTER, 32'h0, RESP_OKAY);
      pins(2'h0);
      wr(OFS_THRESH, 32'h0);
      pins(2'h2);
      wr(OFS_PINBLNK, 32'hc0);
      wr(OFS_THRESH, 32'h32);
      wr(OFS_CMD, 32'h01);
      pins(2'h3);
      smp(16'h0033, 16'h0000, 16'h0000);
      pins(2'h2);
      wr(OFS_CMD, 32'h02);
      rd(OFS_MODE, 32'h0, RESP_OKAY);
      wrap_up();
   end
endmodule : tb_top
